/* File: pkg/ecqc_pkg.sv */
// Shared constants and types for the ECC region write quantum checker
package ecqc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int LEN_W = 8;
  localparam int INIT_W = 8;
  localparam int TYPE_W = 2;
  localparam int NUM_RANGES = 2;

  // ----------------------------------------------------------------
  // Quantum masks on the low address and length bits
  // ----------------------------------------------------------------
  localparam logic [1:0] QUANT_MASK_16 = 2'h1;
  localparam logic [1:0] QUANT_MASK_32 = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [INIT_W-1:0] LOG_INIT_RST = 8'h00;
  localparam logic [TYPE_W-1:0] LOG_TYPE_RST = 2'h0;
  localparam logic [ADDR_W-1:0] LOG_ADDR_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Response stage states
  // ----------------------------------------------------------------
  typedef enum logic {
    ECQC_RSP_IDLE,
    ECQC_RSP_HOLD
  } ecqc_rsp_state_t;

endpackage

/* File: verification/ecqc_init_model.sv */
// Bus initiator model issuing requests to the write quantum checker
`timescale 1ns/10ps
module ecqc_init_model (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic write_o,
  output logic [31:0] addr_o,
  output logic [7:0] len_o,
  output logic [1:0] type_o,
  output logic [7:0] id_o,
  output logic rsp_ready_o
);
  initial begin
    valid_o = 1'h0;
    write_o = 1'h0;
    addr_o = 32'h0;
    len_o = 8'h0;
    type_o = 2'h0;
    id_o = 8'h0;
  end
  // Slow initiator when stalled: response left standing
  assign rsp_ready_o = ~stall_i;
  // Held until taken; bench may break the quantum advice on purpose
  task automatic req(input logic w, input logic [31:0] a, input logic [7:0] l, input logic [1:0] t,
                     input logic [7:0] i);
    @(negedge clk_i);
    valid_o = 1'h1;
    write_o = w;
    addr_o = a;
    len_o = l;
    type_o = t;
    id_o = i;
    // No limit here: giving up would drop a request untaken; the bench timeout catches a hang
    #1;
    while (ready_i !== 1'h1) begin
      @(negedge clk_i);
      #1;
    end
    @(posedge clk_i);
    valid_o <= 1'h0;
    // Released address must not look like a held value
    addr_o <= ~a;
  endtask
endmodule // ecqc_init_model

/* File: verification/test_ecc_region_write_quantum_checker.sv */
// Self-checking bench of the write quantum checker
`timescale 1ns/10ps
module test_ecc_region_write_quantum_checker;
  logic clk_sys_i = 1'h0, reset_n_i = 1'h0, ecc_en = 1'h1, w32 = 1'h1, stall = 1'h0, irq_clr = 1'h0;
  logic [1:0] rng_en = 2'h3;
  logic [1:0][31:0] base = {32'h8000, 32'h1000}, lim = {32'h8fff, 32'h1fff};
  logic vld, rdy, wr, rsp_rdy, rsp_v, rsp_e, irq, log_v, irq_x = 1'h0, logv_x = 1'h0;
  logic [31:0] addr, loga, loga_x = 32'h0;
  logic [7:0] len, typ8, rsp_id, logid, logid_x = 8'h0;
  logic [1:0] typ, logt, logt_x = 2'h0;
  int n_fail = 0, compares = 0, cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  ecqc_init_model ecqc_init_model_inst (.clk_i(clk_sys_i), .stall_i(stall), .ready_i(rdy), .valid_o(vld),
    .write_o(wr), .addr_o(addr), .len_o(len), .type_o(typ), .id_o(typ8), .rsp_ready_o(rsp_rdy));
  ecqc_checker ecqc_checker_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ecc_enable_i(ecc_en),
    .bus_width_32_i(w32), .range_enable_i(rng_en), .range_base_i(base), .range_limit_i(lim),
    .req_valid_i(vld), .req_ready_o(rdy), .req_write_i(wr), .req_addr_i(addr), .req_len_i(len),
    .req_type_i(typ), .req_initiator_i(typ8), .rsp_valid_o(rsp_v), .rsp_ready_i(rsp_rdy),
    .rsp_error_o(rsp_e), .rsp_initiator_o(rsp_id), .irq_o(irq), .irq_clear_i(irq_clr),
    .log_valid_o(log_v), .log_type_o(logt), .log_initiator_o(logid), .log_addr_o(loga));
  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d compares", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Run takes well under 1000 cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic bad(input logic w, input logic [31:0] a, input logic [7:0] l);
    logic [1:0] m;
    logic hit;
    m = w32 ? 2'h3 : 2'h1;
    hit = ecc_en && ((rng_en[0] && a >= base[0] && a <= lim[0]) || (rng_en[1] && a >= base[1] && a <= lim[1]));
    return w && hit && ((a[1:0] & m) != 2'h0 || l == 8'h0 || (l[1:0] & m) != 2'h0);
  endfunction
  // ----------------------------------------------------------------
  // One request with full response, interrupt and log check
  // ----------------------------------------------------------------
  task automatic one(input logic w, input logic [31:0] a, input logic [7:0] l, input logic [1:0] t,
                     input logic [7:0] i, input bit clr);
    logic e;
    e = bad(w, a, l);
    ecqc_init_model_inst.req(w, a, l, t, i);
    if (e) begin
      irq_x = 1'h1;
      logv_x = 1'h1;
      logt_x = t;
      logid_x = i;
      loga_x = a;
    end
    @(negedge clk_sys_i);
    chk("rsp_valid", 32'h1, rsp_v);
    chk("rsp_error", e, rsp_e);
    chk("rsp_id", i, rsp_id);
    chk("irq", irq_x, irq);
    chk("log_valid", logv_x, log_v);
    chk("log_type", logt_x, logt);
    chk("log_id", logid_x, logid);
    chk("log_addr", loga_x, loga);
    if (clr) begin
      irq_clr = 1'h1;
      irq_x = 1'h0;
      @(negedge clk_sys_i);
      irq_clr = 1'h0;
      chk("irq_cleared", 32'h0, irq);
      chk("log_kept", logid_x, logid);
    end
  endtask
  task automatic t_table();
    logic [31:0] ta[9] = '{32'h1000, 32'h1002, 32'h1001, 32'h1000, 32'h1000, 32'h1001, 32'h0ffd, 32'h8fff, 32'h9000};
    logic [7:0] tl[9] = '{8'h4, 8'h2, 8'h2, 8'h3, 8'h0, 8'h1, 8'h1, 8'h1, 8'h1};
    int k, m;
    for (m = 0; m < 4; m++) begin
      w32 = m[0];
      rng_en = (m == 2) ? 2'h1 : 2'h3;
      ecc_en = (m != 3);
      for (k = 0; k < 9; k++) one(k != 5, ta[k], tl[k], k[1:0], 8'h10 + k[7:0], 1'h1);
    end
    w32 = 1'h1;
    rng_en = 2'h3;
    ecc_en = 1'h1;
  endtask
  task automatic t_hold();
    one(1'h1, 32'h1003, 8'h4, 2'h1, 8'h21, 1'h0);
    one(1'h1, 32'h1004, 8'h8, 2'h0, 8'h33, 1'h0);
    one(1'h1, 32'h8002, 8'h2, 2'h2, 8'h42, 1'h1);
  endtask
  // Clear held high across the edge that takes an illegal write: the set must win
  task automatic t_set_clear();
    irq_clr = 1'h1;
    one(1'h1, 32'h1001, 8'h4, 2'h2, 8'h66, 1'h1);
  endtask
  task automatic t_stall();
    @(negedge clk_sys_i);
    stall = 1'h1;
    one(1'h1, 32'h1005, 8'h4, 2'h3, 8'h55, 1'b0);
    chk("req_ready_pending", 32'h0, rdy);
    @(negedge clk_sys_i);
    chk("rsp_stands", 32'h1, rsp_v);
    chk("rsp_err_stands", 32'h1, rsp_e);
    stall = 1'h0;
    @(negedge clk_sys_i);
    chk("rsp_taken", 32'h0, rsp_v);
  endtask
  initial begin
    repeat (8) @(negedge clk_sys_i);
    chk("reset_irq", 32'h0, irq);
    chk("reset_rsp", 32'h0, rsp_v);
    chk("reset_ready", 32'h1, rdy);
    reset_n_i = 1'h1;
    t_table();
    t_hold();
    t_set_clear();
    t_stall();
    tally_and_finish();
  end
endmodule // test_ecc_region_write_quantum_checker

/* File: verilog/ecqc_checker.sv */
// ECC region write quantum checker of the external_memory_controller
// ------------------------------------------------------------------
// Behaviour
// - ECC space accepts only whole aligned quanta
// - Flag short or misaligned writes to ECC space
// - Illegal write raises error interrupt
// - Illegal write returns error response to initiator
// - Legal accesses always get normal response
// - Interrupt never raised by legal transaction
// - Log type and initiator of latest offender
// - ECC enabled per range, or fully off
// ------------------------------------------------------------------
`timescale 1ns/10ps
module ecqc_checker (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Configuration
  input wire logic ecc_enable_i,
  input wire logic bus_width_32_i,
  input wire logic [ecqc_pkg::NUM_RANGES-1:0] range_enable_i,
  input wire logic [ecqc_pkg::NUM_RANGES-1:0][ecqc_pkg::ADDR_W-1:0] range_base_i,
  input wire logic [ecqc_pkg::NUM_RANGES-1:0][ecqc_pkg::ADDR_W-1:0] range_limit_i,
  // Request from on-chip initiators
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [ecqc_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [ecqc_pkg::LEN_W-1:0] req_len_i,
  input wire logic [ecqc_pkg::TYPE_W-1:0] req_type_i,
  input wire logic [ecqc_pkg::INIT_W-1:0] req_initiator_i,
  // Response to the initiator
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic rsp_error_o,
  output logic [ecqc_pkg::INIT_W-1:0] rsp_initiator_o,
  // Interrupt and log
  output logic irq_o,
  input wire logic irq_clear_i,
  output logic log_valid_o,
  output logic [ecqc_pkg::TYPE_W-1:0] log_type_o,
  output logic [ecqc_pkg::INIT_W-1:0] log_initiator_o,
  output logic [ecqc_pkg::ADDR_W-1:0] log_addr_o
);

  // ----------------------------------------------------------------
  // Protected range decode
  // ----------------------------------------------------------------
  logic [ecqc_pkg::NUM_RANGES-1:0] range_hit;
  logic in_ecc_space;

  for (genvar g = 0; g < ecqc_pkg::NUM_RANGES; g++) begin : g_range
    ecqc_range_match u_match (
      .base_i(range_base_i[g]),
      .limit_i(range_limit_i[g]),
      .enable_i(range_enable_i[g]),
      .addr_i(req_addr_i),
      .hit_o(range_hit[g])
    );
  end

  // Global enable overrides every window
  assign in_ecc_space = ecc_enable_i && (|range_hit);

  // ----------------------------------------------------------------
  // Quantum legality
  // ----------------------------------------------------------------
  logic [1:0] quant_mask;
  logic misaligned;
  logic short_len;
  logic illegal_w;
  logic accept;

  assign quant_mask = bus_width_32_i ? ecqc_pkg::QUANT_MASK_32 : ecqc_pkg::QUANT_MASK_16;
  assign misaligned = |(req_addr_i[1:0] & quant_mask);
  // A trailing partial quantum is as harmful as a short write, so it is flagged too
  assign short_len = (req_len_i == '0) || (|(req_len_i[1:0] & quant_mask));
  // Reads never qualify, which keeps read responses clean
  assign illegal_w = req_write_i && in_ecc_space && (misaligned || short_len);

  assign accept = req_valid_i && req_ready_o;

  // ----------------------------------------------------------------
  // Response stage
  // ----------------------------------------------------------------
  ecqc_pkg::ecqc_rsp_state_t rsp_state_r;
  ecqc_pkg::ecqc_rsp_state_t rsp_state_nxt;
  logic rsp_error_r;
  logic [ecqc_pkg::INIT_W-1:0] rsp_initiator_r;

  // One response in flight; a new request is taken as the old one drains
  assign req_ready_o = (rsp_state_r == ecqc_pkg::ECQC_RSP_IDLE) || rsp_ready_i;

  always_comb begin
    rsp_state_nxt = rsp_state_r;
    case (rsp_state_r)
      ecqc_pkg::ECQC_RSP_IDLE: begin
        if (accept) begin
          rsp_state_nxt = ecqc_pkg::ECQC_RSP_HOLD;
        end
      end
      ecqc_pkg::ECQC_RSP_HOLD: begin
        if (rsp_ready_i && !accept) begin
          rsp_state_nxt = ecqc_pkg::ECQC_RSP_IDLE;
        end
      end
      default: begin
        rsp_state_nxt = ecqc_pkg::ECQC_RSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rsp_state_r <= ecqc_pkg::ECQC_RSP_IDLE;
    end else begin
      rsp_state_r <= rsp_state_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rsp_error_r <= 1'h0;
      rsp_initiator_r <= ecqc_pkg::LOG_INIT_RST;
    end else if (accept) begin
      rsp_error_r <= illegal_w;
      rsp_initiator_r <= req_initiator_i;
    end
  end

  assign rsp_valid_o = (rsp_state_r == ecqc_pkg::ECQC_RSP_HOLD);
  assign rsp_error_o = rsp_error_r;
  assign rsp_initiator_o = rsp_initiator_r;

  // ----------------------------------------------------------------
  // Error interrupt
  // ----------------------------------------------------------------
  logic irq_r;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      irq_r <= 1'h0;
    end else if (accept && illegal_w) begin
      irq_r <= 1'h1;
    end else if (irq_clear_i) begin
      irq_r <= 1'h0;
    end
  end

  assign irq_o = irq_r;

  // ----------------------------------------------------------------
  // Offender log
  // ----------------------------------------------------------------
  logic log_valid_r;
  logic [ecqc_pkg::TYPE_W-1:0] log_type_r;
  logic [ecqc_pkg::INIT_W-1:0] log_init_r;
  logic [ecqc_pkg::ADDR_W-1:0] log_addr_r;

  // Newest offender overwrites; no history is kept
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      log_valid_r <= 1'h0;
      log_type_r <= ecqc_pkg::LOG_TYPE_RST;
      log_init_r <= ecqc_pkg::LOG_INIT_RST;
      log_addr_r <= ecqc_pkg::LOG_ADDR_RST;
    end else if (accept && illegal_w) begin
      log_valid_r <= 1'h1;
      log_type_r <= req_type_i;
      log_init_r <= req_initiator_i;
      log_addr_r <= req_addr_i;
    end
  end

  assign log_valid_o = log_valid_r;
  assign log_type_o = log_type_r;
  assign log_initiator_o = log_init_r;
  assign log_addr_o = log_addr_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_RSP_STATUS: assert property (
    accept |=> rsp_valid_o && (rsp_error_o == $past(illegal_w)) && (rsp_initiator_o == $past(req_initiator_i))
  ) else $error("Response status does not match the accepted request");

  AST_READ_CLEAN: assert property (
    accept && !req_write_i |=> rsp_valid_o && !rsp_error_o
  ) else $error("Read returned an error response");

  AST_IRQ_SET: assert property (
    accept && illegal_w |=> irq_o
  ) else $error("Illegal write did not raise the interrupt");

  AST_IRQ_ONLY_TRUE: assert property (
    $rose(irq_o) |-> $past(accept && illegal_w)
  ) else $error("Interrupt rose without an illegal write");

  AST_IRQ_HOLD: assert property (
    irq_o && !irq_clear_i |=> irq_o
  ) else $error("Interrupt dropped without a clear");

  AST_LOG_UPDATE: assert property (
    accept && illegal_w |=> log_valid_o && (log_type_o == $past(req_type_i))
      && (log_initiator_o == $past(req_initiator_i))
  ) else $error("Log does not hold the latest offender");

  AST_LOG_STABLE: assert property (
    !(accept && illegal_w) |=> $stable(log_initiator_o) && $stable(log_type_o)
  ) else $error("Log changed without an illegal write");

  AST_ECC_OFF: assert property (
    accept && !ecc_enable_i ##1 rsp_valid_o |-> !rsp_error_o && !$rose(irq_o)
  ) else $error("Error reported while ECC is disabled");

  AST_MISALIGN: assert property (
    accept && req_write_i && in_ecc_space && req_addr_i[0] |=> rsp_error_o && irq_o
  ) else $error("Odd address write to ECC space not flagged");

  AST_ALIGNED_OK: assert property (
    accept && req_write_i && (req_addr_i[1:0] == 2'h0) && (req_len_i[1:0] == 2'h0) && (req_len_i != '0)
      |=> !rsp_error_o
  ) else $error("Whole aligned write flagged as illegal");

  AST_RSP_HOLD: assert property (
    rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_error_o)
  ) else $error("Response dropped before it was taken");

  COV_ILLEGAL_WRITE: cover property (accept && illegal_w ##1 irq_o);
  COV_LEGAL_ECC_WRITE: cover property (accept && req_write_i && in_ecc_space && !illegal_w);
  COV_SET_OVER_CLEAR: cover property (accept && illegal_w && irq_clear_i ##1 irq_o);
  COV_BACK_TO_BACK: cover property (accept ##1 accept);

endmodule // ecqc_checker

/* File: verilog/ecqc_range_match.sv */
// One address window of ECC protection: hit when enabled and the address falls inside
`timescale 1ns/10ps
module ecqc_range_match (
  input wire logic [ecqc_pkg::ADDR_W-1:0] base_i,
  input wire logic [ecqc_pkg::ADDR_W-1:0] limit_i,
  input wire logic enable_i,
  input wire logic [ecqc_pkg::ADDR_W-1:0] addr_i,
  output logic hit_o
);

  // Limit is inclusive so a window may reach the top of the space
  assign hit_o = enable_i && (addr_i >= base_i) && (addr_i <= limit_i);

endmodule // ecqc_range_match
